// [shared/sleep_ctrl_pkg.sv]
// Constants and types for the sleep-mode controller
package sleep_ctrl_pkg;
   // Sleep mode select encodings
   localparam logic [2:0] MODE_IDLE     = 3'h0;
   localparam logic [2:0] MODE_QUIET    = 3'h1;
   localparam logic [2:0] MODE_PDOWN    = 3'h2;
   localparam logic [2:0] MODE_PSAVE    = 3'h3;
   localparam logic [2:0] MODE_STANDBY  = 3'h6;
   // Register offsets
   localparam logic [7:0] OFS_SLEEP_CTRL = 8'h33;
   localparam logic [7:0] OFS_PROC_CTRL  = 8'h35;
   // Field positions
   localparam int SLEEP_ARM_POS   = 0;
   localparam int MODE_LSB_POS    = 1;
   localparam int BO_OFF_POS      = 6;
   // Reset values
   localparam logic [7:0] SLEEP_CTRL_RST = 8'h00;
   // Timing
   localparam int CLK_MHZ          = 125;
   localparam int HALT_EXTRA_CYC   = 4;
   localparam int BO_WAKE_US       = 60;
   localparam int BO_WAKE_CYC      = BO_WAKE_US * CLK_MHZ;
   localparam int STANDBY_WAKE_CYC = 6;
   localparam int CNT_W            = 16;
   // Sequencer states
   typedef enum logic [4:0] {
      ST_RUN   = 5'b00001,
      ST_SLEEP = 5'b00010,
      ST_START = 5'b00100,
      ST_HOLD  = 5'b01000,
      ST_RESET = 5'b10000
   } seq_state_e;
endpackage

// [sim/sleep_mode_controller_properties.sv]
// Port-level checks of the sleep-mode controller
`timescale 1ns/100ps
module sleep_mode_controller_properties
   import sleep_ctrl_pkg::*;
(
   // Clock, reset, controls
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       halt_insn,
   input wire logic       brownout_off_unlock,
   input wire logic       crystal_selected,
   input wire logic       converter_enabled,
   // Watched outputs
   input wire logic       core_halt,
   input wire logic       wake_to_irq,
   input wire logic       wake_to_reset,
   input wire logic       core_clock_en,
   input wire logic       io_clock_en,
   input wire logic       converter_clock_en,
   input wire logic       main_osc_en,
   input wire logic       brownout_enable,
   input wire logic       conv_start
);
   logic [3:0] ctl_r;
   logic       bo_off_r;
   logic       ok;
   // Shadow of software controls; the unlock gate mirrors the timed sequence
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctl_r <= 4'h0;
         bo_off_r <= 1'b0;
      end else if (reg_wr && reg_addr == OFS_SLEEP_CTRL) begin
         ctl_r <= reg_wdata[3:0];
      end else if (reg_wr && reg_addr == OFS_PROC_CTRL && brownout_off_unlock) begin
         bo_off_r <= reg_wdata[BO_OFF_POS];
      end
   end
   // Standby counts only with a crystal; other high codes are refused
   assign ok = ctl_r[0] && (!ctl_r[3] || (ctl_r[3:1] == MODE_STANDBY && crystal_selected));
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_arm_enters: assert property (!core_halt && halt_insn && ok |=> core_halt)
      else $error("valid halt did not sleep");
   a_halt_refused: assert property (!core_halt && halt_insn && !ok |=> !core_halt)
      else $error("refused halt slept");
   a_idle_gating: assert property ($rose(core_halt) && ctl_r[3:1] == MODE_IDLE |->
      !core_clock_en && io_clock_en && converter_clock_en) else $error("idle gating wrong");
   a_quiet_gating: assert property ($rose(core_halt) && ctl_r[3:1] == MODE_QUIET |->
      !io_clock_en && converter_clock_en) else $error("quiet gating wrong");
   a_pdown_stops: assert property ($rose(core_halt) && ctl_r[3:1] == MODE_PDOWN |->
      !main_osc_en && !converter_clock_en) else $error("power-down clocks running");
   a_standby_osc: assert property ($rose(core_halt) && ctl_r[3:1] == MODE_STANDBY |->
      main_osc_en && !io_clock_en) else $error("standby oscillator wrong");
   a_brownout_off: assert property ($rose(core_halt) && bo_off_r && ctl_r[2] |->
      !brownout_enable) else $error("detector still on in sleep");
   a_brownout_back: assert property (!core_halt |-> brownout_enable)
      else $error("detector off while running");
   a_conv_start: assert property ($rose(core_halt) && converter_enabled && ctl_r[3:2] == 2'h0
      |-> ##[0:1] conv_start) else $error("no conversion on entry");
   a_irq_release: assert property (wake_to_irq |-> core_halt ##1 !core_halt)
      else $error("irq wake did not resume");
   a_reset_release: assert property (wake_to_reset |-> !wake_to_irq ##1 !core_halt)
      else $error("reset wake did not resume");
endmodule
bind sleep_mode_controller sleep_mode_controller_properties chk (
   .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .halt_insn(halt_insn), .brownout_off_unlock(brownout_off_unlock),
   .crystal_selected(crystal_selected),
   .converter_enabled(converter_enabled), .core_halt(core_halt), .wake_to_irq(wake_to_irq),
   .wake_to_reset(wake_to_reset), .core_clock_en(core_clock_en), .io_clock_en(io_clock_en),
   .converter_clock_en(converter_clock_en), .main_osc_en(main_osc_en),
   .brownout_enable(brownout_enable), .conv_start(conv_start));

// [sim/test_sleep_mode_controller.sv]
// Directed bench for the sleep-mode controller
`timescale 1ns/100ps
module test_sleep_mode_controller;
   import sleep_ctrl_pkg::*;
   localparam int BWC = 20; // Short detector wake keeps the run brief
   logic       clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       halt_insn = 1'b0;
   logic       unl = 1'b0;
   logic       gie = 1'b0;
   logic       xtal = 1'b0;
   logic       lvl = 1'b0;
   logic       mhit = 1'b0;
   logic       conv_en = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [9:0] req = 10'h000;
   logic [9:0] src;
   logic [7:0] reg_rdata;
   logic       core_halt, w_irq, w_rst, cke, fke, ioe, cve, ase, mosc, tosc, bode, cst;
   int         n_errors = 0;
   int         cmp_count = 0;
   logic [7:0] bad [5] = '{8'h00, 8'h09, 8'h0b, 8'h0f, 8'h0d};
   always #4 clk = ~clk;
   sleep_mode_controller #(.BO_WAKE_CYCLES(BWC)) uut (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_insn(halt_insn),
      .brownout_off_unlock(unl), .global_irq_en(gie), .core_halt(core_halt),
      .wake_to_irq(w_irq),
      .wake_to_reset(w_rst), .startup_cycles(16'h0005), .crystal_selected(xtal),
      .line0_level_mode(lvl), .timer2_async(1'b1), .timer2_sync(1'b0),
      .converter_enabled(conv_en), .any_irq(src[0]), .ext_reset(src[1]), .wdt_reset(src[2]),
      .brownout_reset(src[3]), .start_cond_irq(src[4]), .line0_irq(src[5]),
      .pin_change_irq(src[6]), .conv_done_irq(src[7]), .timer2_irq(src[8]),
      .timer2_mask_hit(mhit), .nvm_ready_irq(src[9]), .core_clock_en(cke),
      .flash_clock_en(fke), .io_clock_en(ioe), .converter_clock_en(cve),
      .async_timer_clock_en(ase), .main_osc_en(mosc), .timer_osc_en(tosc),
      .brownout_enable(bode), .conv_start(cst));
   wake_src_model part (.clk(clk), .core_halt(core_halt), .req(req), .src(src));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, exp);
   endtask
   task automatic go(input logic [7:0] ctl);
      wr(OFS_SLEEP_CTRL, ctl);
      @(posedge clk);
      halt_insn <= 1'b1;
      @(posedge clk);
      halt_insn <= 1'b0;
      #1;
   endtask
   task automatic fire(input logic [9:0] s);
      @(posedge clk);
      req <= s;
      @(posedge clk);
      req <= 10'h000;
   endtask
   // A refused source must leave the core asleep
   task automatic poke(input logic [9:0] s);
      fire(s);
      repeat (12) @(posedge clk);
      #1 check(core_halt, 1'b1);
   endtask
   // Counts cycles to resume; the window is the wake delay plus the hold
   task automatic resume(input int lo, input logic rst);
      int         n;
      logic [1:0] seen;
      seen = 2'h0;
      for (n = 0; n < 300 && core_halt === 1'b1; n++) begin
         @(posedge clk);
         #1;
         seen = seen | {w_rst, w_irq};
      end
      if (n == 300) begin
         n_errors++;
         conclude();
      end else begin
         check(n >= lo && n <= lo + 4, 1'b1);
         check(seen, rst ? 2'h2 : 2'h1);
      end
   endtask
   // Reset sources take the reset path, all others the interrupt path
   task automatic wake(input logic [9:0] s, input int lo);
      fire(s);
      resume(lo, |s[3:1]);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rdchk(OFS_SLEEP_CTRL, SLEEP_CTRL_RST);
      rdchk(OFS_PROC_CTRL, 8'h00);
      wr(OFS_PROC_CTRL, 8'h40);
      rdchk(OFS_PROC_CTRL, 8'h00);
      unl <= 1'b1;
      wr(OFS_PROC_CTRL, 8'h40);
      unl <= 1'b0;
      rdchk(OFS_PROC_CTRL, 8'h40);
      rdchk(8'h10, 8'h00);
      foreach (bad[i]) begin
         go(bad[i]);
         check(core_halt, 1'b0);
      end
      conv_en <= 1'b1;
      go(8'h01);
      check({cke, fke, ioe, cve, ase}, 5'h07);
      check(cst, 1'b1);
      wake(10'h001, 1 + HALT_EXTRA_CYC);
      go(8'h03);
      check({ioe, cve, ase}, 3'h3);
      poke(10'h001);
      wake(10'h080, 1 + HALT_EXTRA_CYC);
      go(8'h05);
      check({mosc, cve, bode, cst, tosc}, 5'h00);
      poke(10'h100);
      poke(10'h020);
      @(posedge clk);
      lvl <= 1'b1;
      resume(BWC + HALT_EXTRA_CYC, 1'b0);
      check(bode, 1'b1);
      go(8'h07);
      check({tosc, ase}, 2'h3);
      mhit <= 1'b1;
      poke(10'h100);
      @(posedge clk);
      gie <= 1'b1;
      resume(BWC + HALT_EXTRA_CYC, 1'b0);
      unl <= 1'b1;
      wr(OFS_PROC_CTRL, 8'h00);
      unl <= 1'b0;
      xtal <= 1'b1;
      go(8'h0d);
      check({mosc, ioe}, 2'h2);
      wake(10'h010, STANDBY_WAKE_CYC + HALT_EXTRA_CYC);
      go(8'h05);
      wake(10'h002, 5);
      conclude();
   end
endmodule

// [sim/wake_src_model.sv]
// Wake-source model standing in for the peripherals
`timescale 1ns/100ps
module wake_src_model (
   // Clock and core state
   input  wire logic       clk,
   input  wire logic       core_halt,
   // Bench requests and held source lines
   input  wire logic [9:0] req,
   output logic      [9:0] src
);
   logic [9:0] held = 10'h000;
   assign src = held;
   // Sources stay raised until the core runs, so a slow wake cannot miss one
   always @(posedge clk) begin
      if (core_halt !== 1'b1) begin
         held <= 10'h000;
      end else begin
         held <= held | req;
      end
   end
endmodule

// [verilog/sleep_mode_controller.sv]
// Sleep-mode sequencer: arm, enter, clock gating and timed wake-up
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
// Contract
// - Sleep only when arm bit set and halt instruction executes.
// - Enabled interrupt wakes; core held four cycles past start-up.
// - Register file and data memory are never cleared by sleep.
// - Reset during sleep wakes to reset vector.
// - Requested detector shutdown takes effect immediately on entry; applied here in power-down, power-save and standby only.
// - Detector re-enabled automatically on every wake-up.
// - Wake time stretched to about 60 us after detector off.
// - Detector sleep-off bit is bit 6, resets to zero.
// - That bit is written only through a timed sequence with enable.
// - Mode 000 idle stops core and flash clocks only.
// - Idle wakes on external and internal interrupts.
// - Enabled converter starts conversion entering idle or quiet mode.
// - Mode 001 stops io, core and flash clocks.
// - Quiet mode wakes only on its listed sources.
// - Deep modes wake on line zero only when level sensed.
// - Mode 010 power-down stops oscillator and all generated clocks.
// - Power-down wakes only on reset, start, line zero level, pin change.
// - Power-down wake waits the fuse-selected start-up delay.
// - Mode 011 power-save is power-down with timer 2 running.
// - Timer 2 wakes power-save only with mask and global enable.
// - Unused timer oscillator and system clock source stop in power-save.
// - Mode 110 with crystal is standby, oscillator on, six-cycle wake.
// - Codes 100, 101, 111 reserved; control register resets zero.
module sleep_mode_controller
   import sleep_ctrl_pkg::*;
#(
   parameter int BO_WAKE_CYCLES = BO_WAKE_CYC
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // Register port
   input  wire logic [7:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic      [7:0]       reg_rdata,
   // Core interface
   input  wire logic             halt_insn,
   input  wire logic             brownout_off_unlock,
   input  wire logic             global_irq_en,
   output logic                  core_halt,
   output logic                  wake_to_irq,
   output logic                  wake_to_reset,
   // Fuses and configuration
   input  wire logic [CNT_W-1:0] startup_cycles,
   input  wire logic             crystal_selected,
   input  wire logic             line0_level_mode,
   input  wire logic             timer2_async,
   input  wire logic             timer2_sync,
   input  wire logic             converter_enabled,
   // Wake sources
   input  wire logic             any_irq,
   input  wire logic             ext_reset,
   input  wire logic             wdt_reset,
   input  wire logic             brownout_reset,
   input  wire logic             start_cond_irq,
   input  wire logic             line0_irq,
   input  wire logic             pin_change_irq,
   input  wire logic             conv_done_irq,
   input  wire logic             timer2_irq,
   input  wire logic             timer2_mask_hit,
   input  wire logic             nvm_ready_irq,
   // Clock domain and analog controls
   output logic                  core_clock_en,
   output logic                  flash_clock_en,
   output logic                  io_clock_en,
   output logic                  converter_clock_en,
   output logic                  async_timer_clock_en,
   output logic                  main_osc_en,
   output logic                  timer_osc_en,
   output logic                  brownout_enable,
   output logic                  conv_start
);

   localparam int LONG_W = 20;

   // The wake counter width bounds the long detector wake; refuse what it cannot hold
   if (BO_WAKE_CYCLES < 1 || BO_WAKE_CYCLES >= (1 << LONG_W)) begin : g_wake_range
      $error("wake cycle parameter out of range");
   end

   logic [2:0]        mode_r;
   logic              arm_r;
   logic              bo_off_r;
   logic              bo_slept_r;
   seq_state_e        state_r;
   logic [2:0]        smode_r;
   logic [LONG_W-1:0] cnt_r;
   logic [2:0]        halt_cnt_r;
   logic              irq_path_r;
   logic              conv_start_r;
   logic [7:0]        rdata_r;
   logic              mode_valid;
   logic              wake_irq;
   logic              wake_rst;
   logic              deep;
   logic              line0_ok;
   logic [LONG_W-1:0] wake_delay;

   // Register writes; the detector bit needs the core's timed unlock
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode_r    <= SLEEP_CTRL_RST[3:1];
         arm_r     <= SLEEP_CTRL_RST[SLEEP_ARM_POS];
         bo_off_r  <= 1'b0;
      end else if (reg_wr && reg_addr == OFS_SLEEP_CTRL) begin
         arm_r  <= reg_wdata[SLEEP_ARM_POS];
         mode_r <= reg_wdata[MODE_LSB_POS +: 3];
      end else if (reg_wr && reg_addr == OFS_PROC_CTRL && brownout_off_unlock) begin
         bo_off_r <= reg_wdata[BO_OFF_POS];
      end
   end

   // Read data one cycle after the strobe; reserved bits read zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_r <= 8'h00;
      end else if (reg_rd && reg_addr == OFS_SLEEP_CTRL) begin
         rdata_r <= {4'h0, mode_r, arm_r};
      end else if (reg_rd && reg_addr == OFS_PROC_CTRL) begin
         rdata_r <= {1'b0, bo_off_r, 6'h00};
      end else begin
         rdata_r <= 8'h00;
      end
   end
   assign reg_rdata = rdata_r;

   // Mode decode; standby is valid only with a crystal
   always_comb begin
      mode_valid = (mode_r == MODE_IDLE) || (mode_r == MODE_QUIET) ||
                   (mode_r == MODE_PDOWN) || (mode_r == MODE_PSAVE) ||
                   (mode_r == MODE_STANDBY && crystal_selected);
   end

   // Wake qualification for the mode actually slept in
   always_comb begin
      deep     = (smode_r != MODE_IDLE);
      line0_ok = line0_irq && (line0_level_mode || !deep);
      wake_rst = ext_reset || wdt_reset || brownout_reset;
      case (smode_r)
         MODE_IDLE:  wake_irq = any_irq;
         MODE_QUIET: wake_irq = conv_done_irq || start_cond_irq || timer2_irq ||
                                nvm_ready_irq || line0_ok || pin_change_irq;
         MODE_PSAVE: wake_irq = start_cond_irq || line0_ok || pin_change_irq ||
                                (timer2_irq && timer2_mask_hit && global_irq_en);
         default:    wake_irq = start_cond_irq || line0_ok || pin_change_irq;
      endcase
   end

   // Start-up delay: six cycles in standby, one in idle or quiet, fuse time otherwise, long if detector was off
   always_comb begin
      if (bo_slept_r) begin
         wake_delay = LONG_W'(BO_WAKE_CYCLES);
      end else if (smode_r == MODE_STANDBY) begin
         wake_delay = LONG_W'(STANDBY_WAKE_CYC);
      end else if (smode_r == MODE_IDLE || smode_r == MODE_QUIET) begin
         wake_delay = LONG_W'(1);
      end else begin
         wake_delay = {4'h0, startup_cycles};
      end
   end

   // Sequencer; memory contents are untouched since no clear path exists
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r     <= ST_RUN;
         smode_r     <= MODE_IDLE;
         cnt_r       <= '0;
         halt_cnt_r  <= 3'h0;
         irq_path_r  <= 1'b0;
         bo_slept_r  <= 1'b0;
      end else begin
         case (state_r)
            ST_RUN: begin
               // Halt with arm clear or a reserved code simply falls through
               if (halt_insn && arm_r && mode_valid) begin
                  state_r     <= ST_SLEEP;
                  smode_r     <= mode_r;
                  bo_slept_r  <= bo_off_r && (mode_r != MODE_IDLE) &&
                                 (mode_r != MODE_QUIET);
               end
            end
            ST_SLEEP: begin
               if (wake_rst) begin
                  state_r    <= ST_START;
                  irq_path_r <= 1'b0;
                  cnt_r      <= wake_delay;
               end else if (wake_irq) begin
                  state_r    <= ST_START;
                  irq_path_r <= 1'b1;
                  cnt_r      <= wake_delay;
               end
            end
            ST_START: begin
               bo_slept_r <= 1'b0;
               if (cnt_r <= LONG_W'(1)) begin
                  state_r    <= irq_path_r ? ST_HOLD : ST_RESET;
                  halt_cnt_r <= 3'(HALT_EXTRA_CYC);
               end else begin
                  cnt_r <= cnt_r - LONG_W'(1);
               end
            end
            ST_HOLD: begin
               if (halt_cnt_r <= 3'h1) begin
                  state_r <= ST_RUN;
               end else begin
                  halt_cnt_r <= halt_cnt_r - 3'h1;
               end
            end
            ST_RESET: begin
               state_r <= ST_RUN;
            end
            default: state_r <= ST_RUN;
         endcase
      end
   end

   // One-cycle conversion start when entering idle or quiet mode
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         conv_start_r <= 1'b0;
      end else begin
         conv_start_r <= (state_r == ST_RUN) && halt_insn && arm_r && converter_enabled &&
                         (mode_r == MODE_IDLE || mode_r == MODE_QUIET);
      end
   end
   assign conv_start = conv_start_r;

   // Clock gating per mode while asleep or starting up
   logic asleep;
   always_comb begin
      asleep               = (state_r == ST_SLEEP) || (state_r == ST_START);
      core_clock_en        = !asleep;
      flash_clock_en       = !asleep;
      io_clock_en          = !asleep || smode_r == MODE_IDLE;
      converter_clock_en   = !asleep || smode_r == MODE_IDLE || smode_r == MODE_QUIET;
      async_timer_clock_en = !asleep || smode_r == MODE_IDLE || smode_r == MODE_QUIET ||
                             smode_r == MODE_PSAVE;
      main_osc_en          = !asleep || smode_r == MODE_IDLE || smode_r == MODE_QUIET ||
                             smode_r == MODE_STANDBY ||
                             (smode_r == MODE_PSAVE && timer2_sync);
      timer_osc_en         = timer2_async && (!asleep || smode_r == MODE_IDLE ||
                             smode_r == MODE_QUIET || smode_r == MODE_PSAVE);
      brownout_enable      = !(state_r == ST_SLEEP && bo_slept_r);
      core_halt            = (state_r != ST_RUN);
      wake_to_irq          = (state_r == ST_HOLD) && (halt_cnt_r == 3'h1);
      wake_to_reset        = (state_r == ST_RESET);
   end

endmodule
